/* hdl/dcj_params.svh */
// constants for the decade johnson counter and decoder
`ifndef DCJ_PARAMS_SVH
`define DCJ_PARAMS_SVH
`define DCJ_STAGES 5
`define DCJ_OUTS 10
`define DCJ_ZERO_STATE 5'h00
`define DCJ_CARRY_LIMIT 6
`define DCJ_HEAD 0
`define DCJ_SECOND 1
`define DCJ_GATE 2
`define DCJ_CNT0 5'h00
`define DCJ_CNT1 5'h01
`define DCJ_CNT2 5'h03
`define DCJ_CNT3 5'h07
`define DCJ_CNT4 5'h0F
`define DCJ_CNT5 5'h1F
`define DCJ_CNT6 5'h1E
`define DCJ_CNT7 5'h1C
`define DCJ_CNT8 5'h18
`define DCJ_CNT9 5'h10
`define DCJ_DEC_ZERO 10'h001
`define DCJ_CARRY_HIGH 1'h1
`define DCJ_CARRY_LOW 1'h0
`endif

/* hdl/dcj_pkg.sv */
// types for the decade johnson counter and decoder
`include "dcj_params.svh"
package dcj_pkg;
  typedef logic [`DCJ_STAGES-1:0] dcj_ring_t;
  typedef logic [`DCJ_OUTS-1:0] dcj_dec_t;
  typedef struct packed {
    dcj_dec_t dec;
    logic carry_out;
  } dcj_out_t;
  typedef struct packed {
    dcj_ring_t ring;
    dcj_out_t outs;
  } dcj_state_t;
endpackage

/* hdl/dcj_decode.sv */
// two-input decoder from johnson stages to ten one-hot outputs
`timescale 1ns/1ns
module dcj_decode #(
  parameter int STAGES = `DCJ_STAGES
) (
  // johnson stages
  input wire logic [STAGES-1:0] ring,
  // decimal outputs
  output logic [2*STAGES-1:0] dec
);
  always_comb begin
    dec = '0;
    // counts 1..4 and 6..9 look at an adjacent pair of stages
    for (int i = 0; i < STAGES - 1; i++) begin
      dec[i+1] = ring[i] & ~ring[i+1];
      dec[i+STAGES+1] = ~ring[i] & ring[i+1];
    end
    // count 0 and count 5 use the two end stages
    dec[0] = ~ring[0] & ~ring[STAGES-1];
    dec[STAGES] = ring[0] & ring[STAGES-1];
  end
endmodule

/* hdl/dcj_counter.sv */
// decade johnson counter with decoded outputs and carry
// Summary of operation
// - count held in a five-stage twisted ring with ten states
// - ten decimal outputs, only the one matching the count is high
// - count advances on a clock edge while enable input is low
// - enable input high holds the count
// - reset low (rst_n) forces the zero count
// - each decoded output is high for at least one clock period, longer while enable input is high
// - carry completes one low-high cycle every ten counts
// - clearing from five or more raises carry, below five does not
// - illegal ring states fall back into the ten-state sequence
// - each decimal output is a two-input decode of adjacent stages, except zero and five, which use the two end stages
// - clearing to zero raises the zero output
`timescale 1ns/1ns
`include "dcj_params.svh"
module dcj_counter #(
  parameter int STAGES = `DCJ_STAGES
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,

  // control
  input wire logic clk_en_n,
  input wire logic clear,

  // outputs
  output logic [2*STAGES-1:0] dec_out,
  output logic carry_out
);

  // ring plus the outputs it implies, all in one register
  dcj_pkg::dcj_state_t state_ff;
  dcj_pkg::dcj_state_t nxt_state;

  // ring now, its successor, and the ring taken at the next edge
  dcj_pkg::dcj_ring_t ring;
  dcj_pkg::dcj_ring_t step_ring;
  dcj_pkg::dcj_ring_t nxt_ring;

  // outputs that belong to the ring taken at the next edge
  logic [2*STAGES-1:0] nxt_dec;
  logic nxt_carry;

  assign ring = state_ff.ring;

  always_comb begin
    nxt_state = state_ff;
    step_ring = ring;
    nxt_ring = ring;
    nxt_carry = state_ff.outs.carry_out;

    // successor of each of the ten legal patterns
    unique case (ring)
      `DCJ_CNT0: begin
        step_ring = `DCJ_CNT1;
      end

      `DCJ_CNT1: begin
        step_ring = `DCJ_CNT2;
      end

      `DCJ_CNT2: begin
        step_ring = `DCJ_CNT3;
      end

      `DCJ_CNT3: begin
        step_ring = `DCJ_CNT4;
      end

      `DCJ_CNT4: begin
        step_ring = `DCJ_CNT5;
      end

      `DCJ_CNT5: begin
        step_ring = `DCJ_CNT6;
      end

      `DCJ_CNT6: begin
        step_ring = `DCJ_CNT7;
      end

      `DCJ_CNT7: begin
        step_ring = `DCJ_CNT8;
      end

      `DCJ_CNT8: begin
        step_ring = `DCJ_CNT9;
      end

      `DCJ_CNT9: begin
        step_ring = `DCJ_CNT0;
      end

      default: begin
        // illegal pattern: twisted shift with the gate stage masked,
        // so a stray bit dies out and the ring rejoins the sequence
        step_ring[`DCJ_HEAD] = ~ring[STAGES-1];
        step_ring[`DCJ_SECOND] = ring[`DCJ_HEAD];
        step_ring[`DCJ_GATE] = ring[`DCJ_SECOND] &
          (ring[`DCJ_HEAD] | ring[`DCJ_GATE]);
        for (int i = `DCJ_GATE + 1; i < STAGES; i++) begin
          step_ring[i] = ring[i-1];
        end
      end
    endcase

    // clear wins over counting; enable high holds the count
    if (clear) begin
      nxt_ring = `DCJ_ZERO_STATE;
    end else if (!clk_en_n) begin
      nxt_ring = step_ring;
    end else begin
      nxt_ring = ring;
    end

    // carry of the next count; its rise falls on nine to zero
    unique case (nxt_ring)
      `DCJ_CNT0: begin
        nxt_carry = `DCJ_CARRY_HIGH;
      end

      `DCJ_CNT1: begin
        nxt_carry = `DCJ_CARRY_HIGH;
      end

      `DCJ_CNT2: begin
        nxt_carry = `DCJ_CARRY_HIGH;
      end

      `DCJ_CNT3: begin
        nxt_carry = `DCJ_CARRY_HIGH;
      end

      `DCJ_CNT4: begin
        nxt_carry = `DCJ_CARRY_HIGH;
      end

      `DCJ_CNT5: begin
        nxt_carry = `DCJ_CARRY_LOW;
      end

      `DCJ_CNT6: begin
        nxt_carry = `DCJ_CARRY_LOW;
      end

      `DCJ_CNT7: begin
        nxt_carry = `DCJ_CARRY_LOW;
      end

      `DCJ_CNT8: begin
        nxt_carry = `DCJ_CARRY_LOW;
      end

      `DCJ_CNT9: begin
        nxt_carry = `DCJ_CARRY_LOW;
      end

      default: begin
        // outside the sequence carry is simply the inverse of the last stage
        nxt_carry = ~nxt_ring[STAGES-1];
      end
    endcase

    nxt_state.ring = nxt_ring;
    nxt_state.outs.dec = nxt_dec;
    nxt_state.outs.carry_out = nxt_carry;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_ff.ring <= `DCJ_ZERO_STATE;
      state_ff.outs.dec <= `DCJ_DEC_ZERO;
      state_ff.outs.carry_out <= `DCJ_CARRY_HIGH;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // decode the ring the next edge loads, so outputs leave flip-flops
  dcj_decode #(
    .STAGES(STAGES)
  ) u_decode (
    .ring(nxt_ring),
    .dec(nxt_dec)
  );

  // registered outputs change only at an edge: at least one full period each
  assign dec_out = state_ff.outs.dec;
  assign carry_out = state_ff.outs.carry_out;
endmodule

/* dv/dcj_props.sv */
// port assertions for the decade counter
`timescale 1ns/1ns
module dcj_chk #(
  parameter int STAGES = 5
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clk_en_n,
  input wire logic clear,
  input wire logic carry_out,
  input wire logic [2*STAGES-1:0] dec_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  wire run = !clear && !clk_en_n;
  one_hot_a: assert property ($onehot(dec_out))
    else $error("one hot");
  clear_zero_a: assert property (clear |=> dec_out == 1)
    else $error("clear");
  count_hold_a: assert property (
    !clear && clk_en_n |=> $stable(dec_out)) else $error("hold");
  count_step_a: assert property (
    run && !dec_out[9] |=> dec_out == $past(dec_out) << 1)
    else $error("step");
  carry_wrap_a: assert property (
    run && dec_out[9] |=> $rose(carry_out)) else $error("wrap");
  carry_level_a: assert property (
    carry_out == |dec_out[4:0]) else $error("carry");
  clear_high_a: assert property (
    clear && |dec_out[9:6] |=> $rose(carry_out)) else $error("clr hi");
  clear_low_a: assert property (
    clear && |dec_out[4:0] |=> $stable(carry_out)) else $error("clr lo");
endmodule
bind dcj_counter dcj_chk #(.STAGES(STAGES)) dcj_chk_i(.clk_sys(clk_sys),
  .rst_n(rst_n), .clk_en_n(clk_en_n), .clear(clear), .carry_out(carry_out),
  .dec_out(dec_out));

/* dv/dcj_ctl.sv */
// divide-by-(n+1) control that clears the counter at output n
`timescale 1ns/1ns
module dcj_ctl (
  input wire logic ctl_en,
  input wire logic carry_out,
  input wire logic [9:0] dec_out,
  input wire logic [3:0] div_n,
  output logic clear,
  output logic next_clk
);
  // reset held while the nth output stands; it lets go once zero shows
  assign clear = ctl_en && dec_out[div_n];
  // ratios below five never drop carry; for ratios below six the zero output clocks onward
  assign next_clk = (div_n < 6) ? dec_out[0] : carry_out;
endmodule

/* dv/testbench.sv */
// self-checking bench for the decade counter
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 0, rst_n = 0, clk_en_n = 1, ctl_en = 0, clear, carry_out;
  logic next_clk;
  logic [9:0] dec_out;
  logic [3:0] div_n = 4'h9;
  int cnt = 0, n_mismatch = 0, total_checks = 0;
  dcj_counter dcj_counter_i(.clk_sys(clk_sys), .rst_n(rst_n),
    .clk_en_n(clk_en_n), .clear(clear), .dec_out(dec_out),
    .carry_out(carry_out));
  dcj_ctl dcj_ctl_i(.ctl_en(ctl_en), .carry_out(carry_out),
    .dec_out(dec_out), .div_n(div_n), .clear(clear), .next_clk(next_clk));
  initial forever #2 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cnt = (!rst_n || clear) ? 0 : (cnt + !clk_en_n) % 10;
  always @(negedge clk_sys) if (rst_n) begin
    total_checks++;
    if (dec_out !== 10'h1 << cnt) begin
      n_mismatch++;
      $display("unexpected dec_out exp %h seen %h", 10'h1 << cnt, dec_out);
    end
    if (carry_out !== (cnt < 5)) begin
      n_mismatch++;
      $display("unexpected carry_out exp %b seen %b", cnt < 5, carry_out);
    end
    if (ctl_en && next_clk !== (div_n < 6 ? cnt == 0 : cnt < 5)) begin
      n_mismatch++;
      $display("unexpected next_clk seen %b", next_clk);
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #40000 n_mismatch++;
    end_sim;
  end
  initial begin
    void'($urandom(32'h2785));
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    repeat (300) @(posedge clk_sys) clk_en_n <= $urandom % 3 == 0;
    $display("count test ends");
    ctl_en <= 1;
    clk_en_n <= 0;
    for (int i = 1; i < 10; i++) begin
      div_n <= 4'(i);
      repeat (40) @(posedge clk_sys);
    end
    rst_n <= 0;
    @(posedge clk_sys) rst_n <= 1;
    repeat (20) @(posedge clk_sys);
    $display("divide test ends");
    end_sim;
  end
endmodule
